// File: hdl/nibble_bus_pkg.sv
// Shared constants, slot and command types for the nibble bus sequencer
package nibble_bus_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;     // System clock period
  localparam int CYCLE_TIME_NS   = 10800;  // One instruction cycle
  localparam int BUS_CLOCK_KHZ   = 750;    // Nominal bus clock rate
  localparam int SLOTS_PER_CYCLE = 8;      // Bus periods per cycle
  // Longest slot rounds down to whole system clocks
  localparam int SLOT_CLKS = CYCLE_TIME_NS / (SLOTS_PER_CYCLE * CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          PC_W       = 12;      // Program address width
  localparam int          NIB_W      = 4;       // Bus width
  localparam int          RAM_BANKS  = 4;       // RAM bank command lines
  localparam int          FIFO_DEPTH = 16;      // Fetched-word buffer
  localparam logic [11:0] PC_RESET   = 12'h000; // Fetch start address
  localparam logic [1:0]  BANK_RESET = 2'h0;    // First bank line
  localparam logic [3:0]  NIB_ZERO   = 4'h0;    // Logic zero nibble

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ADDRESS_SLOT_ONE,
    ADDRESS_SLOT_TWO,
    ADDRESS_SLOT_THREE,
    FETCH_SLOT_ONE,
    FETCH_SLOT_TWO,
    EXECUTE_SLOT_ONE,
    EXECUTE_SLOT_TWO,
    EXECUTE_SLOT_THREE
  } slot_t;

  typedef enum logic [2:0] {
    EXEC_NONE,      // No bus transfer
    EXEC_ROM_OUT,   // Accumulator to program-memory port
    EXEC_ROM_IN,    // Program-memory port to core
    EXEC_RAM_ADDR,  // Chip/register/character address to RAM
    EXEC_RAM_OUT    // Accumulator to RAM output lines
  } exec_kind_t;

  typedef struct packed {
    exec_kind_t  kind;        // Transfer for the execute slots
    logic [3:0]  acc;         // Accumulator value
    logic [7:0]  pair;        // Index pair: RAM address
    logic [1:0]  bank;        // RAM bank line for address transfers
    logic        jump;        // Load target into program counter
    logic [11:0] target;      // Jump target
    logic        double_len;  // Instruction takes two cycles
  } exec_cmd_t;

  typedef struct packed {
    logic [11:0] addr;             // Address the word came from
    logic [3:0]  opcode_nibble;    // Upper instruction nibble
    logic [3:0]  modifier_nibble;  // Lower instruction nibble
    logic        second_word;      // Second word of a double instruction
  } fetch_word_t;

endpackage : nibble_bus_pkg

// File: hdl/slot_timer.sv
// Bus clock divider and eight-slot instruction cycle counter
`timescale 1ns/10ps
module slot_timer
  import nibble_bus_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CLKS  // System clocks per bus slot
)(
  // Clock and reset
  input  wire logic  mclk_i,
  input  wire logic  rst_n_i,
  // Control
  input  wire logic  hold_i,   // Stretch last slot before a new cycle
  // Timing
  output nibble_bus_pkg::slot_t slot_o,  // Current slot
  output logic       tick_o    // Last clock of the current slot
);
  import nibble_bus_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] cnt_q, cnt_d;    // Clocks within the slot
  slot_t      slot_q, slot_d;  // Slot position

  assign slot_o = slot_q;
  assign tick_o = (cnt_q == 8'(SLOT_LEN - 1)) &&
                  !((slot_q == EXECUTE_SLOT_THREE) && hold_i);

  // Next slot: hold only at the cycle boundary so no cycle is torn
  always_comb
  begin
    cnt_d  = cnt_q;
    slot_d = slot_q;
    if (tick_o)
    begin
      cnt_d  = 8'h00;
      slot_d = slot_t'(slot_q + 3'h1);  // Wraps X3 back to A1
    end
    else if (cnt_q != 8'(SLOT_LEN - 1))
    begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  // Register
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q  <= 8'h00;
      slot_q <= ADDRESS_SLOT_ONE;
    end
    else
    begin
      cnt_q  <= cnt_d;
      slot_q <= slot_d;
    end
  end

  slot_step_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tick_o |=> slot_q == slot_t'($past(slot_q) + 3'h1))  // [R1]
    else $error("slot did not advance after its last clock");

endmodule : slot_timer

// File: hdl/word_fifo.sv
// Fetched-word FIFO with registered output stage
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 21,  // Word width
  parameter int DEPTH = 16   // Storage entries
)(
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;       // Entries in storage
  logic             ov_q, ov_d;         // Output stage holds a word
  logic [WIDTH-1:0] od_q, od_d;         // Output stage data
  logic             push, pop;

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));  // Honest full
  assign out_valid_o = ov_q;
  assign out_data_o  = od_q;
  assign push = in_valid_i && in_ready_o;
  assign pop  = (cnt_q != '0) && (!ov_q || out_ready_i);

  // Pointer, count and output stage next values
  always_comb
  begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    ov_d  = pop ? 1'b1 : (out_ready_i ? 1'b0 : ov_q);
    od_d  = pop ? mem_q[rd_q] : od_q;
  end

  // Register
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      ov_q  <= 1'b0;
      od_q  <= '0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      ov_q  <= ov_d;
      od_q  <= od_d;
    end
  end

  // Entry storage, one write port per entry
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge mclk_i)
    begin
      if (push && (wr_q == AW'(i)))
      begin
        mem_q[i] <= in_data_i;
      end
    end
  end

endmodule : word_fifo

// File: hdl/nibble_bus_cycle_sequencer.sv
// Eight-slot instruction cycle sequencer on the shared nibble bus
`timescale 1ns/10ps
// Behaviour
// R1: Cycle-start marker once every eight slots
// R2: Instructions take one or two cycles
// R3: Cycle lasts 10.8 us nominally
// R4: Address sent as three nibbles first
// R5: Memories decode chip and word from address
// R6: Selected memory returns instruction in two slots
// R7: Execute work happens in last three slots
// R8: Port data moves in second execute slot
// R9: RAM address sent in execute slots two, three
// R10: Four RAM bank lines, one program line
// R11: RAM output puts accumulator on bus
// R12: Reset clears, restart at zero, bank zero
// R13: Bus and control lines are negative logic
// R14: Two clock phases come from outside; design runs from the single mclk_i instead
// R15: Memories time slots from the marker
// R16: One driver per line, others float
// R17: Many receivers may sample a line
// R18: Upper nibble first, lower nibble second
// R19: Reset held 64 periods clears fully
// R20: Bus floats during both fetch slots
module nibble_bus_cycle_sequencer
  import nibble_bus_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CLKS,  // System clocks per slot [R3]
  parameter int DEPTH    = FIFO_DEPTH  // Fetched-word buffer depth
)(
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  // Data bus pins, electrical levels
  input  wire logic [3:0]        bus_in_i,
  output logic [3:0]             bus_out_o,
  output logic [3:0]             bus_oe_o,
  // Control pins, active low
  output logic                   sync_n_o,
  output logic                   program_memory_command_line_n_o,
  output logic [RAM_BANKS-1:0]   ram_bank_command_line_n_o,
  // Core command for the execute slots
  input  wire logic              cmd_valid_i,
  input  nibble_bus_pkg::exec_cmd_t cmd_i,
  // Fetched instruction stream
  output logic                   word_valid_o,
  input  wire logic              word_ready_i,
  output nibble_bus_pkg::fetch_word_t word_o,
  // Port input result
  output logic                   port_valid_o,
  output logic [3:0]             port_data_o
);
  import nibble_bus_pkg::*;

  // ----------------------------------------------------------------
  // Slot timing
  // ----------------------------------------------------------------
  slot_t       slot;            // Current slot
  logic        tick;            // Last clock of the slot
  logic        fifo_ready;      // Buffer can take the next word
  logic [3:0]  bus_logic;       // Bus in logical sense

  // Stall at the cycle boundary while the buffer is full, so the
  // next fetch always has room; costs bus cycles, never words.
  slot_timer #(
    .SLOT_LEN (SLOT_LEN)
  ) u_timer (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .hold_i  (!fifo_ready),
    .slot_o  (slot),
    .tick_o  (tick)
  );

  // Pins carry logic one as the low level
  // Input side only listens, so other receivers may share the line
  assign bus_logic = ~bus_in_i;  // [R13] [R17]

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  logic [11:0]  pc_q, pc_d;          // Program address
  logic [3:0]   opc_q, opc_d;        // Captured upper nibble
  exec_cmd_t    cmd_q, cmd_d;        // Command for this cycle
  logic [1:0]   bank_q, bank_d;      // Selected RAM bank line
  logic         second_q, second_d;  // This fetch is a second word
  logic [3:0]   pdat_q, pdat_d;      // Port input data
  logic         pval_q, pval_d;      // Port input strobe
  logic         push;                // Word complete
  fetch_word_t  push_word;           // Word going to the buffer

  assign push_word = '{addr: pc_q, opcode_nibble: opc_q,
                       modifier_nibble: bus_logic, second_word: second_q};

  // Slot-end actions: capture, advance, latch commands
  always_comb
  begin
    pc_d     = pc_q;
    opc_d    = opc_q;
    cmd_d    = cmd_q;
    bank_d   = bank_q;
    second_d = second_q;
    pdat_d   = pdat_q;
    pval_d   = 1'b0;
    push     = 1'b0;
    if (tick)
    begin
      case (slot)
        FETCH_SLOT_ONE:
        begin
          opc_d = bus_logic;  // Upper nibble arrives first [R18] [R6]
        end
        FETCH_SLOT_TWO:
        begin
          push = 1'b1;          // Lower nibble completes the word [R18]
          pc_d = pc_q + 12'h001;
        end
        EXECUTE_SLOT_ONE:
        begin
          // Second word of a double instruction carries no transfer [R2]
          if (cmd_valid_i && !second_q)
          begin
            cmd_d = cmd_i;
          end
          else
          begin
            cmd_d = '0;
          end
          second_d = !second_q && cmd_valid_i && cmd_i.double_len;  // [R2]
        end
        EXECUTE_SLOT_TWO:
        begin
          if (cmd_q.kind == EXEC_ROM_IN)
          begin
            pdat_d = bus_logic;  // Port value from program memory [R8]
            pval_d = 1'b1;
          end
          else if (cmd_q.kind == EXEC_RAM_ADDR)
          begin
            bank_d = cmd_q.bank;  // Bank stays for later transfers [R10]
          end
        end
        EXECUTE_SLOT_THREE:
        begin
          if (cmd_q.jump)
          begin
            pc_d = cmd_q.target;  // Executed late in the cycle [R7]
          end
        end
        default:
        begin
          pc_d = pc_q;
        end
      endcase
    end
  end

  // Register sequencer state; reset restarts at zero, bank zero
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pc_q     <= PC_RESET;    // [R12]
      opc_q    <= NIB_ZERO;
      cmd_q    <= '0;
      bank_q   <= BANK_RESET;  // [R12]
      second_q <= 1'b0;
      pdat_q   <= NIB_ZERO;
      pval_q   <= 1'b0;
    end
    else
    begin
      pc_q     <= pc_d;
      opc_q    <= opc_d;
      cmd_q    <= cmd_d;
      bank_q   <= bank_d;
      second_q <= second_d;
      pdat_q   <= pdat_d;
      pval_q   <= pval_d;
    end
  end

  assign port_valid_o = pval_q;
  assign port_data_o  = pdat_q;

  // ----------------------------------------------------------------
  // Pin drive, one clock behind the slot
  // ----------------------------------------------------------------
  logic [3:0]           bus_lg;        // Nibble to drive, logical
  logic                 bus_en;        // Drive enable
  logic [3:0]           out_q, out_d;  // Pin levels
  logic [3:0]           oe_q, oe_d;    // Pin enables
  logic                 sync_q, sync_d;
  logic                 rom_q, rom_d;
  logic [RAM_BANKS-1:0] ram_q, ram_d;
  logic [RAM_BANKS-1:0] bank_low;      // Current bank line, low active
  logic [RAM_BANKS-1:0] cmd_low;       // Command's bank line

  assign bank_low = ~(4'h1 << bank_q);
  assign cmd_low  = ~(4'h1 << cmd_q.bank);

  // Decide who drives the bus in each slot
  always_comb
  begin
    bus_lg = NIB_ZERO;
    bus_en = 1'b0;
    rom_d  = 1'b1;
    ram_d  = 4'hF;
    sync_d = (slot != ADDRESS_SLOT_ONE);  // Marks cycle start [R1] [R15]
    case (slot)
      ADDRESS_SLOT_ONE:
      begin
        bus_lg = pc_q[3:0];  // [R4] [R5]
        bus_en = 1'b1;
      end
      ADDRESS_SLOT_TWO:
      begin
        bus_lg = pc_q[7:4];  // [R4]
        bus_en = 1'b1;
      end
      ADDRESS_SLOT_THREE:
      begin
        bus_lg = pc_q[11:8];  // [R4]
        bus_en = 1'b1;
        rom_d  = 1'b0;        // Program bank enabled for the fetch [R10]
        ram_d  = bank_low;    // [R10]
      end
      FETCH_SLOT_ONE, FETCH_SLOT_TWO:
      begin
        bus_en = 1'b0;  // Memory owns the bus [R20] [R16]
      end
      EXECUTE_SLOT_TWO:
      begin
        case (cmd_q.kind)
          EXEC_ROM_OUT:
          begin
            bus_lg = cmd_q.acc;  // [R8]
            bus_en = 1'b1;
            rom_d  = 1'b0;
          end
          EXEC_ROM_IN:
          begin
            rom_d = 1'b0;  // Port drives, we only listen [R8] [R16]
          end
          EXEC_RAM_ADDR:
          begin
            bus_lg = cmd_q.pair[7:4];  // [R9]
            bus_en = 1'b1;
            ram_d  = cmd_low;          // [R10]
          end
          EXEC_RAM_OUT:
          begin
            bus_lg = cmd_q.acc;  // [R11]
            bus_en = 1'b1;
            ram_d  = bank_low;
          end
          default:
          begin
            bus_en = 1'b0;
          end
        endcase
      end
      EXECUTE_SLOT_THREE:
      begin
        if (cmd_q.kind == EXEC_RAM_ADDR)
        begin
          bus_lg = cmd_q.pair[3:0];  // [R9]
          bus_en = 1'b1;
        end
      end
      default:
      begin
        bus_en = 1'b0;
      end
    endcase
    out_d = ~bus_lg;  // Negative logic on the pins [R13]
    oe_d  = {4{bus_en}};
  end

  // Register pins; reset leaves bus at logic zero and released
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_q  <= ~NIB_ZERO;
      oe_q   <= 4'h0;
      sync_q <= 1'b1;
      rom_q  <= 1'b1;
      ram_q  <= 4'hF;
    end
    else
    begin
      out_q  <= out_d;
      oe_q   <= oe_d;
      sync_q <= sync_d;
      rom_q  <= rom_d;
      ram_q  <= ram_d;
    end
  end

  assign bus_out_o                       = out_q;
  assign bus_oe_o                        = oe_q;
  assign sync_n_o                        = sync_q;
  assign program_memory_command_line_n_o = rom_q;
  assign ram_bank_command_line_n_o       = ram_q;

  // ----------------------------------------------------------------
  // Fetched-word buffer
  // ----------------------------------------------------------------
  word_fifo #(
    .WIDTH ($bits(fetch_word_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (push_word),
    .out_valid_o (word_valid_o),
    .out_ready_i (word_ready_i),
    .out_data_o  (word_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Pins still show reset levels on the edges right after release,
  // so a slot only counts once reset was already gone a clock ago
  sequence s_prev_slot(slot_t s);
    $past(rst_n_i) && $past(slot) == s;
  endsequence

  sequence s_prev_kind(exec_kind_t k);
    $past(rst_n_i) && $past(slot) == EXECUTE_SLOT_TWO && $past(cmd_q.kind) == k;
  endsequence

  sync_slot_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // [R1]
    !sync_n_o |-> s_prev_slot(ADDRESS_SLOT_ONE))
    else $error("cycle marker outside first address slot");

  fetch_float_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // [R20]
    (s_prev_slot(FETCH_SLOT_ONE) or s_prev_slot(FETCH_SLOT_TWO)) |-> bus_oe_o == 4'h0)
    else $error("bus driven during a fetch slot");

  addr_nibble_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // [R4]
    s_prev_slot(ADDRESS_SLOT_ONE) |-> bus_oe_o == 4'hF && bus_out_o == ~$past(pc_q[3:0]))
    else $error("low address nibble wrong");

  ram_addr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // [R9]
    s_prev_kind(EXEC_RAM_ADDR) |-> bus_out_o == ~$past(cmd_q.pair[7:4])
      && ram_bank_command_line_n_o == ~(4'h1 << $past(cmd_q.bank)))
    else $error("RAM address transfer wrong");

  ram_out_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // [R11]
    s_prev_kind(EXEC_RAM_OUT) |-> bus_oe_o == 4'hF && bus_out_o == ~$past(cmd_q.acc))
    else $error("accumulator not on bus for RAM output");

  rom_port_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // [R8]
    s_prev_kind(EXEC_ROM_OUT) |-> !program_memory_command_line_n_o
      && bus_out_o == ~$past(cmd_q.acc))
    else $error("port output transfer wrong");

  one_bank_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // [R10]
    $onehot0(~ram_bank_command_line_n_o))
    else $error("more than one bank line active");

  fetch_push_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)  // [R6]
    (tick && slot == FETCH_SLOT_TWO) |=> pc_q == $past(pc_q) + 12'h001)
    else $error("address did not advance after fetch");

endmodule : nibble_bus_cycle_sequencer

// File: tb/rom_port_model.sv
// Program memory and port model facing the sequencer across the nibble bus
`timescale 1ns/10ps
module rom_port_model #(
  parameter int L = 6  // System clocks per slot
)(
  // Clock and sequencer pins
  input  wire logic       mclk_i,
  input  wire logic       sync_n_i,
  input  wire logic       prog_n_i,
  input  wire logic [3:0] bus_out_i,
  input  wire logic [3:0] bus_oe_i,
  // Port value offered on input
  input  wire logic [3:0] port_val_i,
  // Resolved pin levels
  output logic      [3:0] bus_o
);
  int          cnt_q  = 1000;    // Clocks since the marker was seen
  logic        sync_q = 1'b1;    // Marker level at the last edge
  logic        drv_q  = 1'b0;    // Model drives the bus
  logic [3:0]  dat_q  = 4'h0;    // Logical nibble driven
  logic [3:0]  junk_q = 4'h5;    // Released lines toggle every clock
  logic [11:0] adr_q  = 12'h000; // Captured program address

  // Released lines never keep stale data, so a late sample shows up
  assign bus_o = (bus_oe_i == 4'hF) ? bus_out_i : (drv_q ? ~dat_q : junk_q);

  // Slot timing from the marker; address in, instruction and port out
  always @(posedge mclk_i)
  begin
    int c;
    c = (!sync_n_i && sync_q) ? 0 : cnt_q + 1;
    sync_q <= sync_n_i;
    cnt_q  <= c;
    junk_q <= ~junk_q;
    drv_q  <= 1'b0;
    // Low nibble first, pin levels inverted
    if (c % L == 1 && c < 3 * L)
      adr_q[4 * (c / L) +: 4] <= ~bus_out_i;
    // Upper nibble in first fetch slot, lower in second
    if (c > 3 * L && c < 5 * L)
    begin
      drv_q <= 1'b1;
      dat_q <= (c < 4 * L) ? adr_q[3:0] ^ adr_q[11:8] : adr_q[7:4] ^ 4'h5;
    end
    // Port input answered only while the processor floats
    if (c > 6 * L && c < 7 * L && !prog_n_i && bus_oe_i == 4'h0)
    begin
      drv_q <= 1'b1;
      dat_q <= port_val_i;
    end
  end
endmodule : rom_port_model

// File: tb/nibble_bus_cycle_sequencer_test.sv
// Self-checking bench for the nibble bus cycle sequencer
`timescale 1ns/10ps
module nibble_bus_cycle_sequencer_test;
  import nibble_bus_pkg::*;
  localparam int L = 6;             // Short slot keeps the run brief
  logic        mclk_i     = 1'b0;   // System clock
  logic        rst_n_i    = 1'b0;   // Reset, active low
  logic [3:0]  bus_in, bus_out, bus_oe, ram_n, port_data;
  logic [3:0]  port_val   = 4'h0;   // Port value for the model to return
  logic        sync_n, prog_n, word_valid, port_valid;
  logic        cmd_valid  = 1'b0;   // Command offered
  logic        word_ready = 1'b0;   // Consumer ready
  exec_cmd_t   cmd        = '0;     // Command for execute slots
  fetch_word_t word;                // Fetched word out
  fetch_word_t exp_q[$];            // Expected words in order
  logic [11:0] pc = 12'h000;        // Expected fetch address
  logic [1:0]  bank = 2'h0;         // Expected bank line
  logic        sec = 1'b0;          // Next cycle is a second word
  bit          stall = 1'b0;        // Consumer held off
  int          error_cnt, checked, pos, cyc, pulses, rom_in_n, stretched;

  // Clock
  always #10 mclk_i = ~mclk_i;

  nibble_bus_cycle_sequencer #(.SLOT_LEN(L), .DEPTH(16)) DUT (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_in_i(bus_in), .bus_out_o(bus_out),
    .bus_oe_o(bus_oe), .sync_n_o(sync_n), .program_memory_command_line_n_o(prog_n),
    .ram_bank_command_line_n_o(ram_n), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .word_valid_o(word_valid), .word_ready_i(word_ready), .word_o(word),
    .port_valid_o(port_valid), .port_data_o(port_data));

  rom_port_model #(.L(L)) mem (
    .mclk_i(mclk_i), .sync_n_i(sync_n), .prog_n_i(prog_n), .bus_out_i(bus_out),
    .bus_oe_i(bus_oe), .port_val_i(port_val), .bus_o(bus_in));

  // Compare and count
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Advance to a negedge offset from the cycle start
  task automatic go(input int off);
    while (pos < off)
    begin
      @(negedge mclk_i);
      pos++;
    end
  endtask : go

  // Consumer, random ready; hang guard
  always @(posedge mclk_i)
  begin
    word_ready <= stall ? 1'b0 : 1'($urandom_range(0, 1));
    pulses += (rst_n_i && port_valid === 1'b1) ? 1 : 0;
    if (rst_n_i && word_valid === 1'b1 && word_ready)
    begin
      chk(exp_q.size() > 0 && word === exp_q[0], "fetched word");
      if (exp_q.size() > 0)
        void'(exp_q.pop_front());
    end
    if (++cyc == 30000)
    begin
      error_cnt++;
      close_out();
    end
  end

  // One bus cycle: command, pins slot by slot, expected state update
  task automatic run_cycle(input int n);
    exec_cmd_t c;
    int k;
    logic eff;
    c = exec_cmd_t'(31'($urandom));
    c.kind = exec_kind_t'($urandom_range(0, 4));
    c.jump = (n == 5) || ($urandom_range(0, 7) == 0);
    c.target = (n == 5) ? 12'hFFF : c.target;  // Wrap of the increment
    k = 0;
    while (sync_n !== 1'b0 && k < 20 * L)
    begin
      @(negedge mclk_i);
      k++;
      stall = stall && (k < 10 * L);  // Let a stretched cycle go on
    end
    if (n > 0 && n < 120)
      chk(k == L - 1, "cycle length");
    stretched += (k > L - 1) ? 1 : 0;
    pos = 0;
    eff = !sec;
    exp_q.push_back('{addr: pc, opcode_nibble: pc[3:0] ^ pc[11:8],
                      modifier_nibble: pc[7:4] ^ 4'h5, second_word: sec});
    chk(bus_oe === 4'hF && bus_out === ~pc[3:0], "address one");
    @(posedge mclk_i);
    cmd <= c;
    cmd_valid <= 1'b1;
    port_val <= 4'($urandom);
    go(L + 1);
    chk(sync_n === 1'b1 && bus_out === ~pc[7:4], "address two");
    go(2 * L + 1);
    chk(bus_out === ~pc[11:8] && prog_n === 1'b0 && ram_n === ~(4'h1 << bank), "a3");
    go(3 * L + 1);
    chk(bus_oe === 4'h0, "fetch one float");
    go(4 * L + 1);
    chk(bus_oe === 4'h0, "fetch two float");
    go(6 * L + 1);
    if (!eff || c.kind == EXEC_NONE)
      chk(bus_oe === 4'h0 && ram_n === 4'hF, "idle execute");
    else if (c.kind == EXEC_ROM_OUT)
      chk(bus_oe === 4'hF && bus_out === ~c.acc && prog_n === 1'b0, "port out");
    else if (c.kind == EXEC_ROM_IN)
      chk(bus_oe === 4'h0 && prog_n === 1'b0, "port in");
    else if (c.kind == EXEC_RAM_ADDR)
      chk(bus_out === ~c.pair[7:4] && ram_n === ~(4'h1 << c.bank), "ram hi");
    else
      chk(bus_out === ~c.acc && ram_n === ~(4'h1 << bank), "ram out");
    go(7 * L + 1);
    if (eff && c.kind == EXEC_RAM_ADDR)
      chk(bus_oe === 4'hF && bus_out === ~c.pair[3:0], "ram lo");
    if (eff && c.kind == EXEC_ROM_IN)
      chk(port_data === port_val, "port data");
    rom_in_n += (eff && c.kind == EXEC_ROM_IN) ? 1 : 0;
    bank = (eff && c.kind == EXEC_RAM_ADDR) ? c.bank : bank;
    pc = (eff && c.jump) ? c.target : pc + 12'h001;
    sec = eff && c.double_len;
  endtask : run_cycle

  // Main sequence
  initial
  begin
    void'($urandom(88));
    repeat (6) @(posedge mclk_i);
    chk(bus_oe === 4'h0 && sync_n === 1'b1 && prog_n === 1'b1 && ram_n === 4'hF
        && word_valid === 1'b0 && port_valid === 1'b0, "reset levels");
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;  // Sequencer clears at once; long hold only for memory refresh
    for (int n = 0; n < 200; n++)
    begin
      stall = stall || (n == 120);  // Fill the buffer until it refuses
      run_cycle(n);
    end
    stall = 1'b0;
    for (int i = 0; i < 2000 && exp_q.size() > 0; i++)
      @(negedge mclk_i);
    chk(exp_q.size() == 0 && stretched > 0, "buffer drained");
    chk(pulses == rom_in_n, "port pulses");
    close_out();
  end
endmodule : nibble_bus_cycle_sequencer_test
